// [include/rxa_pkg.sv]
// constants, pin groups and state layout of the repeater expansion port
// assumes one common clock of 40 MHz shared by every repeater chip
package rxa_pkg;
  localparam int CLK_NS = 25;
  localparam int RST_HOLD_NS = 500;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_CYCLE_NS = 100;
  localparam int BUS_CYC = (BUS_CYCLE_NS / CLK_NS < 1) ? 1 :
                           BUS_CYCLE_NS / CLK_NS;
  // timing that the party driving reset and serial input must keep
  localparam int PWRUP_RST_NS = 150000;
  localparam int REARM_RST_NS = 4000;
  localparam int SI_HOLD_NS = 500;
  localparam int RST_CNT_W = 6;
  localparam int BIT_CNT_W = 3;
  localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_HOLD_CYC);
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(BUS_CYC - 1);
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] LINK_ADDR = 8'h04;
  localparam logic [7:0] POL_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0c;
  localparam int CTRL_TP_ALT_BIT = 0;
  localparam int CTRL_AUI_ALT_BIT = 1;
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_GRANT_BIT = 1;
  localparam int STAT_COLL_BIT = 2;
  localparam int STAT_MULTI_BIT = 3;
  localparam int STAT_RJAM_BIT = 4;
  localparam int STAT_RDAT_BIT = 5;
  localparam int STAT_FSM_LSB = 8;
  localparam int STAT_FAIL_LSB = 16;
  localparam logic [7:0] LINK_EN_RST = 8'hff;
  localparam logic [7:0] LINK_FAIL_RST = 8'hff;
  localparam logic [7:0] POL_EN_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB = 3'b001,
    ST_TRANS = 3'b011,
    ST_DRIVE = 3'b010,
    ST_LEFT = 3'b110
  } rxa_fsm_type;

  typedef struct packed {
    logic dat_i;
    logic jam_i;
    logic ack_n;
    logic col_n;
  } rxa_exp_in_type;

  typedef struct packed {
    logic req_n;
    logic dat_o;
    logic dat_oe;
    logic jam_o;
    logic jam_oe;
  } rxa_exp_out_type;

  typedef struct packed {
    logic active;
    logic data;
    logic coll_one;
    logic coll_many;
    logic runt;
    logic [7:0] link_up;
    logic [7:0] link_lost;
  } rxa_core_in_type;

  typedef struct packed {
    logic coll;
    logic granted;
    logic remote_jam;
    logic remote_dat;
  } rxa_core_out_type;

  typedef struct packed {
    logic tp_alt;
    logic aui_alt;
    logic [7:0] link_en;
    logic [7:0] link_fail;
    logic [7:0] pol_en;
  } rxa_cfg_type;

  typedef struct packed {
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [BIT_CNT_W-1:0] bit_cnt;
    rxa_fsm_type fsm;
    logic coll;
    logic multi_seen;
    logic runt_seen;
    rxa_cfg_type cfg;
    rxa_exp_out_type exp;
    rxa_core_out_type core;
    logic str_o;
    logic str_oe;
    logic so_o;
    logic [31:0] rd_data;
  } rxa_state_type;
endpackage : rxa_pkg

// [src/rxa_expansion.sv]
// expansion port of one repeater chip: request, grant and collision
// handling on the shared data and status lines, reset stretching and the
// options that reset restores, plus a small register port
// assumes every chip and the external arbiter share clk and a reset
// released on the same edge; arbiter answers combinationally
`timescale 1ns/100ps

// Contract
// - reset holds internally after pin rises
// - reset drives outputs inactive, lines released
// - internal reset pulse has guaranteed minimum
// - reset restores standard options and link fail
// - all chips share clock, five-pin port
// - active chip sends NRZ data per bus cycle
// - status line high while jamming collision
// - data line tells one or many collisions
// - runt signals one-port-left one cycle first
// - request asserted while active chip needs lines
// - multi-active input treated as collision
// - transitional cycle: nobody drives, all jam
// - afterwards sole active chip drives, in collision
module rxa_expansion (
  input wire logic clk,
  input wire logic rst_n,
  input rxa_pkg::rxa_exp_in_type exp_in,
  output rxa_pkg::rxa_exp_out_type exp_out,
  input rxa_pkg::rxa_core_in_type core_in,
  output rxa_pkg::rxa_core_out_type core_out,
  output rxa_pkg::rxa_cfg_type cfg,
  output logic str_o,
  output logic str_oe,
  output logic so_o,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data
);
  import rxa_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // the status bit map lives in one place so the read port and any later
  // user cannot drift apart
  function automatic logic [31:0] status_word(input rxa_state_type st);
    logic [31:0] w;
    w = RD_ZERO;
    w[STAT_REQ_BIT] = ~st.exp.req_n;
    w[STAT_GRANT_BIT] = st.core.granted;
    w[STAT_COLL_BIT] = st.coll;
    w[STAT_MULTI_BIT] = st.multi_seen;
    w[STAT_RJAM_BIT] = st.core.remote_jam;
    w[STAT_RDAT_BIT] = st.core.remote_dat;
    w[STAT_FSM_LSB +: 3] = st.fsm;
    w[STAT_FAIL_LSB +: 8] = st.cfg.link_fail;
    status_word = w;
  endfunction : status_word

  // what this chip puts on the shared lines for the coming bus cycle;
  // released lines carry zero so a stale level never lingers in the flops
  function automatic rxa_exp_out_type lines_next(input logic own,
                                                 input logic left,
                                                 input logic jam,
                                                 input rxa_core_in_type c);
    rxa_exp_out_type o;
    o = '0;
    o.dat_oe = own;
    o.jam_oe = own;
    if (own && left) begin
      o.jam_o = 1'b1;
      o.dat_o = 1'b1;
    end else if (own && jam) begin
      o.jam_o = 1'b1;
      // high for a single colliding port, low for several
      o.dat_o = c.coll_one && !c.coll_many;
    end else if (own) begin
      o.dat_o = c.data;
    end
    lines_next = o;
  endfunction : lines_next

  localparam rxa_state_type RESET_STATE = '{
    rst_cnt: '0,
    bit_cnt: '0,
    fsm: ST_IDLE,
    coll: 1'b0,
    multi_seen: 1'b0,
    runt_seen: 1'b0,
    cfg: '{
      tp_alt: 1'b0,
      aui_alt: 1'b0,
      link_en: LINK_EN_RST,
      link_fail: LINK_FAIL_RST,
      pol_en: POL_EN_RST
    },
    exp: '{
      req_n: 1'b1,
      dat_o: 1'b0,
      dat_oe: 1'b0,
      jam_o: 1'b0,
      jam_oe: 1'b0
    },
    core: '{
      coll: 1'b0,
      granted: 1'b0,
      remote_jam: 1'b0,
      remote_dat: 1'b0
    },
    str_o: 1'b0,
    str_oe: 1'b1,
    so_o: 1'b1,
    rd_data: RD_ZERO
  };

  rxa_state_type s_q;
  rxa_state_type s_d;

  logic tick;
  logic ack;
  logic multi;
  logic drive;
  logic jam_val;
  logic [31:0] stat_word;
  logic [7:0] fail_nx;

  // each port keeps its own sticky fail bit; on an enabled port a loss beside a recovery wins
  for (genvar p = 0; p < 8; p++) begin : g_link
    assign fail_nx[p] = (s_q.cfg.link_fail[p] & ~core_in.link_up[p]) |
                        (core_in.link_lost[p] & s_q.cfg.link_en[p]);
  end

  always_comb begin
    s_d = s_q;
    tick = (s_q.bit_cnt == BIT_LAST);
    // arbiter lines are active low on the pins, positive logic inside
    // the arbiter is combinational on every chip's request, so its answer
    // in a cycle already reflects the request that this chip shows
    ack = ~exp_in.ack_n;
    multi = ~exp_in.col_n;
    drive = 1'b0;
    jam_val = 1'b0;
    stat_word = status_word(s_q);

    if (!rst_n) begin
      // any low sample reloads the stretch, so a rippling edge cannot
      // cut the internal pulse short
      s_d = RESET_STATE;
      s_d.rst_cnt = RST_LOAD;
    end else if (s_q.rst_cnt != '0) begin
      s_d = RESET_STATE;
      s_d.rst_cnt = s_q.rst_cnt - RST_CNT_W'(1);
    end else begin
      // carrier strobe function lives outside this block; let it go
      s_d.str_oe = 1'b0;
      s_d.str_o = 1'b0;
      s_d.bit_cnt = tick ? '0 : s_q.bit_cnt + BIT_CNT_W'(1);

      s_d.cfg.link_fail = fail_nx;

      if (core_in.active && core_in.runt) begin
        s_d.runt_seen = 1'b1;
      end

      // the expansion bus only moves on bus cycle boundaries
      if (tick) begin
        unique case (s_q.fsm)
          ST_IDLE: begin
            // request only once the core has traffic, never speculatively
            if (core_in.active) begin
              s_d.fsm = ST_ARB;
            end
          end
          ST_ARB: begin
            if (!core_in.active) begin
              s_d.fsm = ST_IDLE;
            end else if (multi) begin
              s_d.coll = 1'b1;
              s_d.multi_seen = 1'b1;
            end else if (ack && s_q.multi_seen) begin
              s_d.fsm = ST_TRANS;
            end else if (ack) begin
              s_d.fsm = ST_DRIVE;
            end
          end
          ST_TRANS: begin
            // one bus cycle with lines released while still jamming
            if (!core_in.active) begin
              s_d.fsm = ST_IDLE;
            end else if (multi) begin
              s_d.fsm = ST_ARB;
            end else if (ack) begin
              s_d.fsm = ST_DRIVE;
            end else begin
              s_d.fsm = ST_ARB;
            end
          end
          ST_DRIVE: begin
            if (multi) begin
              s_d.fsm = ST_ARB;
              s_d.coll = 1'b1;
              s_d.multi_seen = 1'b1;
            end else if (!core_in.active) begin
              s_d.fsm = (s_q.runt_seen || core_in.runt) ?
                        ST_LEFT : ST_IDLE;
            end else if (!ack) begin
              // a lost grant is not a collision; wait for it again
              s_d.fsm = ST_ARB;
            end
          end
          ST_LEFT: begin
            // request drops only after the one-port-left cycle is out
            s_d.fsm = ST_IDLE;
          end
        endcase

        if (s_d.fsm == ST_IDLE) begin
          s_d.coll = 1'b0;
          s_d.multi_seen = 1'b0;
          s_d.runt_seen = 1'b0;
        end
        if (s_d.fsm == ST_DRIVE) begin
          s_d.multi_seen = 1'b0;
        end

        // only the sole granted chip owns the shared lines
        drive = ack && !multi &&
                ((s_d.fsm == ST_DRIVE) || (s_d.fsm == ST_LEFT));
        jam_val = s_d.coll || core_in.coll_one || core_in.coll_many;
        s_d.exp = lines_next(drive, s_d.fsm == ST_LEFT, jam_val, core_in);
        s_d.exp.req_n = (s_d.fsm == ST_IDLE);

        s_d.core.granted = drive;
        // the transitional cycle keeps the core jamming
        s_d.core.coll = s_d.coll || multi ||
                        (s_d.fsm == ST_TRANS);
        // while another chip is active its status tells ours
        s_d.core.remote_jam = !drive && exp_in.jam_i;
        s_d.core.remote_dat = !drive && exp_in.dat_i;
      end

      if (wr_en) begin
        if (hit(addr, CTRL_ADDR)) begin
          // alternate reconnection can only be chosen; reset undoes it
          s_d.cfg.tp_alt = s_q.cfg.tp_alt | wr_data[CTRL_TP_ALT_BIT];
          s_d.cfg.aui_alt = s_q.cfg.aui_alt | wr_data[CTRL_AUI_ALT_BIT];
        end
        if (hit(addr, LINK_ADDR)) begin
          s_d.cfg.link_en = wr_data[7:0];
        end
        if (hit(addr, POL_ADDR)) begin
          s_d.cfg.pol_en = wr_data[7:0];
        end
      end

      // read data stands for one cycle only, so a stale word is never seen
      s_d.rd_data = RD_ZERO;
      if (rd_en) begin
        if (hit(addr, CTRL_ADDR)) begin
          s_d.rd_data[CTRL_TP_ALT_BIT] = s_q.cfg.tp_alt;
          s_d.rd_data[CTRL_AUI_ALT_BIT] = s_q.cfg.aui_alt;
        end else if (hit(addr, LINK_ADDR)) begin
          s_d.rd_data[7:0] = s_q.cfg.link_en;
        end else if (hit(addr, POL_ADDR)) begin
          s_d.rd_data[7:0] = s_q.cfg.pol_en;
        end else if (hit(addr, STAT_ADDR)) begin
          s_d.rd_data = stat_word;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign exp_out = s_q.exp;
  assign core_out = s_q.core;
  assign cfg = s_q.cfg;
  assign str_o = s_q.str_o;
  assign str_oe = s_q.str_oe;
  assign so_o = s_q.so_o;
  assign rd_data = s_q.rd_data;
endmodule : rxa_expansion

// [tb/rxa_arb_model.sv]
// far side of the expansion port: combinational arbiter over this chip and
// one peer agent, plus the resolved shared data and status lines
`timescale 1ns/100ps
module rxa_arb_model (
  input wire logic req_a_n,
  input wire logic req_b_n,
  input rxa_pkg::rxa_exp_out_type dut_out,
  output rxa_pkg::rxa_exp_in_type lines
);
  import rxa_pkg::*;
  logic one_req;
  logic any_req;
  assign any_req = !req_a_n || !req_b_n;
  assign one_req = req_a_n ^ req_b_n;
  assign lines.ack_n = !one_req;
  assign lines.col_n = !(any_req && !one_req);
  // released lines settle at the pull-down level, never the last value
  assign lines.dat_i = dut_out.dat_oe ? dut_out.dat_o : 1'b0;
  // a lone peer is the last agent left and keeps the status line up
  assign lines.jam_i = dut_out.jam_oe ? dut_out.jam_o : !req_b_n && req_a_n;
endmodule : rxa_arb_model

// [tb/rxa_expansion_properties.sv]
// timing checks on the expansion port outputs of one repeater chip
// assumes one clock domain and tb inputs held steady over a bus cycle
`timescale 1ns/100ps
module rxa_expansion_properties (
  input wire logic clk,
  input wire logic rst_n,
  input rxa_pkg::rxa_exp_in_type exp_in,
  input rxa_pkg::rxa_exp_out_type exp_out,
  input rxa_pkg::rxa_core_in_type core_in,
  input rxa_pkg::rxa_core_out_type core_out,
  input rxa_pkg::rxa_cfg_type cfg,
  input wire logic str_o,
  input wire logic str_oe,
  input wire logic so_o
);
  import rxa_pkg::*;
  logic [5:0] up_q;
  logic [5:0] up_d;
  default clocking cb @(posedge clk);
  endclocking
  // saturating count of edges since reset was last released
  always_comb begin
    up_d = up_q;
    if (!rst_n)
      up_d = 6'h00;
    else if (up_q != 6'h3f)
      up_d = up_q + 6'h01;
  end
  always_ff @(posedge clk) begin
    up_q <= up_d;
  end
  sequence s_left;
    (!exp_out.req_n && exp_out.jam_o && exp_out.dat_o) [*4]
      ##1 (exp_out.req_n && !exp_out.dat_oe);
  endsequence
  sequence s_trans;
    (!exp_out.dat_oe && core_out.coll) [*4] ##[1:6] exp_out.dat_oe;
  endsequence
  property p_rst_state;
    !rst_n |=> exp_out.req_n && !exp_out.dat_oe && !exp_out.jam_oe && so_o
      && str_oe && !str_o && cfg.link_fail == LINK_FAIL_RST
      && cfg.pol_en == POL_EN_RST && !cfg.tp_alt && !cfg.aui_alt;
  endproperty
  property p_stretch;
    disable iff (!rst_n) up_q < 6'h14 |-> exp_out.req_n
      && !exp_out.dat_oe && core_out == '0;
  endproperty
  property p_hold;
    disable iff (!rst_n) exp_out.dat_oe && $changed(exp_out.dat_o)
      |=> $stable(exp_out.dat_o) [*3];
  endproperty
  property p_one_coll;
    disable iff (!rst_n) $rose(exp_out.jam_o && exp_out.jam_oe)
      && $past(core_in.coll_one || core_in.coll_many)
      |-> exp_out.dat_o == $past(core_in.coll_one && !core_in.coll_many);
  endproperty
  property p_left;
    disable iff (!rst_n) $rose(exp_out.jam_o && exp_out.dat_o && exp_out.jam_oe)
      && !$past(core_in.coll_one || core_in.coll_many) |-> s_left;
  endproperty
  property p_req;
    disable iff (!rst_n) $fell(exp_out.req_n) |-> $past(core_in.active);
  endproperty
  property p_multi;
    disable iff (!rst_n) (!exp_in.col_n && !exp_out.req_n) [*5]
      |-> core_out.coll && !exp_out.dat_oe;
  endproperty
  property p_trans;
    disable iff (!rst_n) $rose(exp_in.col_n) && !exp_in.ack_n
      && core_out.coll && core_in.active |-> s_trans;
  endproperty
  property p_grant;
    disable iff (!rst_n) $rose(exp_out.dat_oe)
      |-> $past(!exp_in.ack_n && exp_in.col_n) && !exp_out.req_n;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("outputs not inactive during reset");
  a_stretch: assert property (p_stretch)
    else $error("activity inside reset stretch");
  a_hold: assert property (p_hold)
    else $error("data bit shorter than a bus cycle");
  a_one_coll: assert property (p_one_coll)
    else $error("data line does not tell collision count");
  a_left: assert property (p_left)
    else $error("one-port-left signal not one bus cycle");
  a_req: assert property (p_req)
    else $error("request without activity");
  a_multi: assert property (p_multi)
    else $error("multi-active not taken as collision");
  a_trans: assert property (p_trans)
    else $error("transitional cycle wrong");
  a_grant: assert property (p_grant)
    else $error("lines driven without sole grant");
endmodule : rxa_expansion_properties

bind rxa_expansion rxa_expansion_properties u_props (
  .clk(clk),
  .rst_n(rst_n),
  .exp_in(exp_in),
  .exp_out(exp_out),
  .core_in(core_in),
  .core_out(core_out),
  .cfg(cfg),
  .str_o(str_o),
  .str_oe(str_oe),
  .so_o(so_o)
);

// [tb/tb.sv]
// self-checking bench for the expansion port: register reads and writes,
// lone drive, collisions, multi-chip arbitration, runt and mid-run reset
`timescale 1ns/100ps
module tb;
  import rxa_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  rxa_exp_in_type bus_in;
  rxa_exp_out_type exp_out;
  rxa_core_in_type core_in = '0;
  rxa_core_out_type core_out;
  rxa_cfg_type cfg;
  logic str_o;
  logic str_oe;
  logic so_o;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic peer_req_n = 1'b1;
  logic [31:0] rv;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  rxa_expansion DUT (.clk(clk), .rst_n(rst_n), .exp_in(bus_in),
    .exp_out(exp_out), .core_in(core_in), .core_out(core_out), .cfg(cfg),
    .str_o(str_o), .str_oe(str_oe), .so_o(so_o), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  rxa_arb_model u_arb (.req_a_n(exp_out.req_n), .req_b_n(peer_req_n),
    .dut_out(exp_out), .lines(bus_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read data is taken 1 ns after the edge that launched it
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask : rd
  initial begin
    cyc(6);
    check(32'({exp_out.req_n, exp_out.dat_oe, exp_out.jam_oe, str_o,
      str_oe, so_o}), 32'h0000_0023);
    rst_n <= 1'b1;
    rd(LINK_ADDR, rv);
    check(rv, 32'h0000_0000);
    cyc(22);
    rd(LINK_ADDR, rv);
    check(rv, 32'h0000_00ff);
    rd(POL_ADDR, rv);
    check(rv, 32'h0000_0000);
    rd(CTRL_ADDR, rv);
    check(rv, 32'h0000_0000);
    rd(STAT_ADDR, rv);
    check(32'(rv[23:16]), 32'h0000_00ff);
    wr(CTRL_ADDR, 32'h0000_0003);
    wr(CTRL_ADDR, 32'h0000_0000);
    wr(POL_ADDR, 32'h0000_005a);
    rd(CTRL_ADDR, rv);
    check(rv, 32'h0000_0003);
    rd(POL_ADDR, rv);
    check(rv, 32'h0000_005a);
    rd(8'h10, rv);
    check(rv, 32'h0000_0000);
    core_in.link_up <= 8'h11;
    cyc(1);
    core_in.link_up <= 8'h00;
    rd(STAT_ADDR, rv);
    check(32'(rv[23:16]), 32'h0000_00ee);
    wr(LINK_ADDR, 32'h0000_000f);
    core_in.link_lost <= 8'h11;
    cyc(1);
    core_in.link_lost <= 8'h00;
    rd(STAT_ADDR, rv);
    check(32'(rv[23:16]), 32'h0000_00ef);
    rd(LINK_ADDR, rv);
    check(rv, 32'h0000_000f);
    core_in.active <= 1'b1;
    core_in.data <= 1'b1;
    cyc(12);
    check(32'(exp_out), 32'h0000_000d);
    check(32'(core_out), 32'h0000_0004);
    check(32'(bus_in.dat_i), 32'h0000_0001);
    core_in.data <= 1'b0;
    cyc(8);
    check(32'(exp_out), 32'h0000_0005);
    core_in.coll_one <= 1'b1;
    cyc(8);
    check(32'(exp_out), 32'h0000_000f);
    core_in.coll_many <= 1'b1;
    cyc(8);
    check(32'(exp_out), 32'h0000_0007);
    core_in.coll_one <= 1'b0;
    core_in.coll_many <= 1'b0;
    core_in.active <= 1'b0;
    cyc(8);
    check(32'(exp_out), 32'h0000_0010);
    core_in.active <= 1'b1;
    peer_req_n <= 1'b0;
    cyc(12);
    check(32'({core_out.coll, exp_out.dat_oe}), 32'h0000_0002);
    peer_req_n <= 1'b1;
    cyc(3);
    check(32'({core_out.coll, exp_out.dat_oe}), 32'h0000_0002);
    cyc(10);
    check(32'({exp_out.dat_oe, exp_out.jam_oe}), 32'h0000_0003);
    core_in.active <= 1'b0;
    cyc(8);
    core_in.runt <= 1'b1;
    core_in.active <= 1'b1;
    cyc(12);
    core_in.active <= 1'b0;
    cyc(4);
    check(32'(exp_out), 32'h0000_000f);
    core_in.runt <= 1'b0;
    cyc(8);
    check(32'(exp_out), 32'h0000_0010);
    core_in.active <= 1'b1;
    cyc(12);
    rst_n <= 1'b0;
    cyc(160);
    check(32'(exp_out), 32'h0000_0010);
    rst_n <= 1'b1;
    cyc(10);
    check(32'(exp_out), 32'h0000_0010);
    cyc(30);
    check(32'(exp_out.req_n), 32'h0000_0000);
    core_in.active <= 1'b0;
    cyc(8);
    peer_req_n <= 1'b0;
    cyc(8);
    check(32'(core_out), 32'h0000_0002);
    peer_req_n <= 1'b1;
    report_and_stop();
  end
endmodule : tb
